// >>> hdl/gpio_port_pkg.sv
// Purpose: constants of the port mode and port 1 data block
// Assumes: 16-bit registers, one per aligned 32-bit bus word
// Notes: register index = low 12 bits of the printed offset
package gpio_port_pkg;
  // ***********************************************************************
  // register offsets (index; byte address is four times the index)
  // ***********************************************************************
  localparam logic [31:0] PORT0_PIN7_CONFIG_OFS = 32'h5000_3014;
  localparam logic [31:0] PORT1_LEVEL_WORD_OFS = 32'h5000_3020;
  localparam logic [31:0] PORT1_BIT_RAISE_OFS = 32'h5000_3022;
  localparam logic [31:0] PORT1_BIT_LOWER_OFS = 32'h5000_3024;
  localparam logic [31:0] PORT1_PIN0_CONFIG_OFS = 32'h5000_3026;
  localparam logic [31:0] PORT1_PIN1_CONFIG_OFS = 32'h5000_3028;
  localparam logic [31:0] PORT1_PIN2_CONFIG_OFS = 32'h5000_302a;
  localparam logic [31:0] PORT1_PIN3_CONFIG_OFS = 32'h5000_302c;
  localparam logic [31:0] PORT1_PIN4_CONFIG_OFS = 32'h5000_302e;
  localparam logic [31:0] PORT1_PIN5_CONFIG_OFS = 32'h5000_3030;
  localparam int ADDR_W = 14;
  // ***********************************************************************
  // field layout and reset values
  // ***********************************************************************
  localparam int PULL_LSB = 8;
  localparam int FUNC_LSB = 0;
  localparam int FUNC_W = 5;
  localparam int P1_W = 8;
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_UP = 2'h1;
  localparam logic [1:0] PULL_DOWN = 2'h2;
  localparam logic [1:0] PULL_OUTPUT = 2'h3;
  localparam logic [1:0] PULL_RESET = 2'h2;
  localparam logic [1:0] PULL_RESET_P1_UP = 2'h1;
  localparam logic [4:0] FUNC_RESET = 5'h00;
  localparam logic [7:0] P1_LATCH_RESET = 8'h00;
  // ***********************************************************************
  // pin function codes
  // ***********************************************************************
  localparam logic [4:0] FUNC_PORT = 5'h00;
  localparam logic [4:0] FUNC_I2C_CLK = 5'h09;
  localparam logic [4:0] FUNC_I2C_DATA = 5'h0a;
  localparam logic [4:0] FUNC_ANALOG = 5'h0f;
  localparam logic [4:0] FUNC_RADIO_DIAG = 5'h12;
  localparam logic [4:0] FUNC_LAST = 5'h19;
  localparam int NFUNC = 26;
  // codes that feed a peripheral input (receive, serial_in_function, cts, i2c)
  localparam logic [25:0] IN_FUNC_MASK = 26'h028_2e2a;
  // codes that drive the pin from a peripheral
  localparam logic [25:0] OUT_FUNC_MASK = 26'h3d7_51d4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gpio_port_pkg

// >>> hdl/gpio_port_mode_data.sv
// Purpose: pin mode registers and port 1 data latch behind an AXI4-Lite slave
// Assumes: peripheral signals are on clk_sys; pin inputs are asynchronous
// Notes: pin vector bit 0 is port 0 pin 7, bits 1.. are port 1 pins 0..
//
// How it works
// - pull selector 00 gives a bare input, 01 an input with pull-up, 10 with pull-down.
// - pull selector 11 drives the pin as an output with both resistors off.
// - an analog converter function turns pulls and drive off whatever the pull selector.
// - every mode register pull selector except port 1 pins 4 and 5 resets to 2, input with pull-down.
// - function selector resets to 0, and 0 makes the pin a port bit under its pull setting.
// - codes 1 to 25 route a peripheral signal; code 15 only on port 0 pins 3 to 0.
// - code 18, radio_diag_out, only on port 0 pins 7 to 0.
// - an input function on several pins is taken from port 0 first, then lowest pin.
// - writing port1_level_word loads the port 1 output latch; it resets to 0.
// - reading port1_level_word returns the live port 1 pin levels.
// - writing port1_bit_raise sets latch bits written as 1; it reads as 0.
// - writing port1_bit_lower clears latch bits written as 1; it reads as 0.
// - port 1 pins 4 and 5 reset with pull selector 1, input with pull-up.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module gpio_port_mode_data
  import gpio_port_pkg::*;
#(
  parameter int P1_CFG_PINS = 6
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic p0_pin7_in,
  input wire logic p0_pin7_latch,
  input wire logic [P1_W-1:0] p1_pin_in,
  output logic [P1_CFG_PINS:0] pin_out,
  output logic [P1_CFG_PINS:0] pin_oe,
  output logic [P1_CFG_PINS:0] pin_pull_up,
  output logic [P1_CFG_PINS:0] pin_pull_down,
  output logic [P1_W-1:0] p1_latch,
  input wire logic [NFUNC-1:0] periph_out,
  output logic [NFUNC-1:0] periph_in
);
  localparam int NPIN = P1_CFG_PINS + 1;

  // ***********************************************************************
  // elaboration checks
  // ***********************************************************************
  generate
    if (P1_CFG_PINS < 1 || P1_CFG_PINS > 6) begin : g_bad_pins
      $error("P1_CFG_PINS must lie in 1..6");
    end
    if (NFUNC != int'(FUNC_LAST) + 1) begin : g_bad_codes
      $error("NFUNC must cover every function code");
    end
    if (ADDR_W < 14) begin : g_bad_addr
      $error("ADDR_W too narrow for the register map");
    end
    if (FUNC_W != 5 || FUNC_LSB + FUNC_W > PULL_LSB) begin : g_bad_fields
      $error("function field must be 5 bits below the pull field");
    end
    if (PULL_LSB + 2 > 16) begin : g_bad_pull
      $error("pull field must sit in the low 16 bits");
    end
    if (P1_W > 8 || P1_W < P1_CFG_PINS) begin : g_bad_width
      $error("port 1 latch width does not fit the configured pins");
    end
    if (PULL_RESET == PULL_OUTPUT || PULL_RESET_P1_UP == PULL_OUTPUT) begin : g_bad_reset
      $error("pins must come out of reset undriven");
    end
  endgenerate

  // ***********************************************************************
  // decode helpers
  // ***********************************************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [31:0] ofs);
    hit = (a == {ofs[ADDR_W-3:0], 2'b00});
  endfunction : hit

  function automatic logic [31:0] cfg_ofs(input int p);
    case (p)
      0: cfg_ofs = PORT0_PIN7_CONFIG_OFS;
      1: cfg_ofs = PORT1_PIN0_CONFIG_OFS;
      2: cfg_ofs = PORT1_PIN1_CONFIG_OFS;
      3: cfg_ofs = PORT1_PIN2_CONFIG_OFS;
      4: cfg_ofs = PORT1_PIN3_CONFIG_OFS;
      5: cfg_ofs = PORT1_PIN4_CONFIG_OFS;
      default: cfg_ofs = PORT1_PIN5_CONFIG_OFS;
    endcase
  endfunction : cfg_ofs

  // pin 0 is on port 0 (pin 7); the rest are port 1, so no analog pin here
  function automatic logic func_ok(input int p, input logic [4:0] f);
    func_ok = (f <= FUNC_LAST) && (f != FUNC_ANALOG)
      && (f != FUNC_RADIO_DIAG || p == 0);
  endfunction : func_ok

  // ***********************************************************************
  // input synchronisers
  // ***********************************************************************
  logic [P1_W:0] sync_a;
  logic [P1_W:0] sync_b;
  logic [NPIN-1:0] pin_level;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {p1_pin_in, p0_pin7_in};
      sync_b <= sync_a;
    end
  end

  assign pin_level = sync_b[NPIN-1:0];

  // ***********************************************************************
  // register bus
  // ***********************************************************************
  logic aw_full;
  logic w_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [1:0] pull_cfg [NPIN];
  logic [4:0] func_cfg [NPIN];
  logic wr_hit_any;
  logic [31:0] next_rdata;
  logic rd_hit_any;
  logic wr_level;
  logic wr_raise;
  logic wr_lower;
  logic rd_level;
  logic rd_raise;
  logic rd_lower;

  assign wr_level = hit(aw_addr, PORT1_LEVEL_WORD_OFS);
  assign wr_raise = hit(aw_addr, PORT1_BIT_RAISE_OFS);
  assign wr_lower = hit(aw_addr, PORT1_BIT_LOWER_OFS);
  assign rd_level = hit(s_axi_araddr, PORT1_LEVEL_WORD_OFS);
  assign rd_raise = hit(s_axi_araddr, PORT1_BIT_RAISE_OFS);
  assign rd_lower = hit(s_axi_araddr, PORT1_BIT_LOWER_OFS);
  assign do_write = aw_full && w_full && !s_axi_bvalid;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit_any ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_comb begin
    wr_hit_any = wr_level || wr_raise || wr_lower;
    rd_hit_any = rd_level || rd_raise || rd_lower;
    next_rdata = '0;
    if (rd_level) begin
      next_rdata[P1_W-1:0] = sync_b[P1_W:1];
    end
    if (rd_raise || rd_lower) begin
      next_rdata = '0;
    end
    for (int p = 0; p < NPIN; p++) begin
      wr_hit_any = wr_hit_any || hit(aw_addr, cfg_ofs(p));
      if (hit(s_axi_araddr, cfg_ofs(p))) begin
        rd_hit_any = 1'b1;
        next_rdata[PULL_LSB+1:PULL_LSB] = pull_cfg[p];
        next_rdata[FUNC_LSB+FUNC_W-1:FUNC_LSB] = func_cfg[p];
      end
    end
  end

  // raise and lower registers fall through with zero read data
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= rd_hit_any ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ***********************************************************************
  // port 1 output latch
  // ***********************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      p1_latch <= P1_LATCH_RESET;
    end else if (do_write && w_strb[0]) begin
      if (wr_level) begin
        p1_latch <= w_data[P1_W-1:0];
      end else if (wr_raise) begin
        p1_latch <= p1_latch | w_data[P1_W-1:0];
      end else if (wr_lower) begin
        p1_latch <= p1_latch & ~w_data[P1_W-1:0];
      end
    end
  end

  // ***********************************************************************
  // mode registers and pin drivers
  // ***********************************************************************
  for (genvar p = 0; p < NPIN; p++) begin : g_pin
    localparam logic [1:0] PULL_INIT = (p == 5 || p == 6) ? PULL_RESET_P1_UP : PULL_RESET;
    logic next_out;
    logic next_oe;
    logic next_pu;
    logic next_pd;
    logic port_bit;

    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        pull_cfg[p] <= PULL_INIT;
        func_cfg[p] <= FUNC_RESET;
      end else if (do_write && hit(aw_addr, cfg_ofs(p))) begin
        if (w_strb[1]) begin
          pull_cfg[p] <= w_data[PULL_LSB+1:PULL_LSB];
        end
        if (w_strb[0]) begin
          func_cfg[p] <= w_data[FUNC_LSB+FUNC_W-1:FUNC_LSB];
        end
      end
    end

    assign port_bit = (p == 0) ? p0_pin7_latch : p1_latch[(p == 0) ? 0 : p-1];

    always_comb begin
      next_out = 1'b0;
      next_oe = 1'b0;
      next_pu = (pull_cfg[p] == PULL_UP);
      next_pd = (pull_cfg[p] == PULL_DOWN);
      if (!func_ok(p, func_cfg[p])) begin
        next_pu = 1'b0;
        next_pd = 1'b0;
      end else if (func_cfg[p] == FUNC_PORT) begin
        next_oe = (pull_cfg[p] == PULL_OUTPUT);
        next_out = port_bit;
      end else if (func_cfg[p] == FUNC_I2C_CLK || func_cfg[p] == FUNC_I2C_DATA) begin
        next_oe = !periph_out[func_cfg[p]];
        next_out = 1'b0;
      end else if (OUT_FUNC_MASK[func_cfg[p]]) begin
        next_oe = 1'b1;
        next_out = periph_out[func_cfg[p]];
        next_pu = 1'b0;
        next_pd = 1'b0;
      end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        pin_out[p] <= 1'b0;
        pin_oe[p] <= 1'b0;
        pin_pull_up[p] <= 1'b0;
        pin_pull_down[p] <= 1'b0;
      end else begin
        pin_out[p] <= next_out;
        pin_oe[p] <= next_oe;
        pin_pull_up[p] <= next_pu;
        pin_pull_down[p] <= next_pd;
      end
    end
  end

  // ***********************************************************************
  // peripheral input routing
  // ***********************************************************************
  logic [NFUNC-1:0] next_periph_in;

  always_comb begin
    next_periph_in = '0;
    for (int c = 1; c < NFUNC; c++) begin
      for (int p = NPIN - 1; p >= 0; p--) begin
        if (IN_FUNC_MASK[c] && func_cfg[p] == 5'(c) && func_ok(p, func_cfg[p])) begin
          next_periph_in[c] = pin_level[p];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      periph_in <= '0;
    end else begin
      periph_in <= next_periph_in;
    end
  end
endmodule : gpio_port_mode_data

// >>> tb/gpio_port_mode_data_props.sv
// Purpose: port checker for gpio_port_mode_data
// Assumes: one clock, reset active low
// Notes: bound to every instance of the top module
`timescale 1ns/1ps
module gpio_port_mode_data_props
  import gpio_port_pkg::*;
#(
  parameter int P1_CFG_PINS = 6
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [P1_CFG_PINS:0] pin_pull_up,
  input wire logic [P1_CFG_PINS:0] pin_pull_down,
  input wire logic [P1_W-1:0] p1_latch,
  input wire logic [NFUNC-1:0] periph_in
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ********************************
  // port relations
  // ********************************
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write not closed");
  property p_latch_wr; $changed(p1_latch) |-> $rose(s_axi_bvalid); endproperty
  a_latch_wr: assert property (p_latch_wr) else $error("latch moved without write");
  property p_pull_excl; (pin_pull_up & pin_pull_down) == '0; endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
  property p_reset_pull;
    $rose(resetn) |-> ##1 pin_pull_down[4:0] == 5'h1f && pin_pull_up[6:5] == 2'h3;
  endproperty
  a_reset_pull: assert property (p_reset_pull) else $error("reset pulls wrong");
  property p_out_func; (periph_in & OUT_FUNC_MASK) == '0; endproperty
  a_out_func: assert property (p_out_func) else $error("output code fed inward");
  property p_rd_resv;
    s_axi_rvalid |-> s_axi_rdata[31:10] == '0
      && (s_axi_rdata[9:8] == '0 || s_axi_rdata[7:5] == '0);
  endproperty
  a_rd_resv: assert property (p_rd_resv) else $error("reserved bits set");
endmodule : gpio_port_mode_data_props

bind gpio_port_mode_data gpio_port_mode_data_props #(.P1_CFG_PINS(P1_CFG_PINS)) props_u (
  .clk_sys, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .pin_pull_up, .pin_pull_down, .p1_latch, .periph_in);

// >>> tb/pad_model.sv
// Purpose: pad levels of the port pins
// Assumes: pad 0 is port 0 pin 7, pads 1..8 port 1 pins 0..7
// Notes: a pad with no drive, no pull and no outside level toggles
`timescale 1ns/1ps
module pad_model
  import gpio_port_pkg::*;
#(
  parameter int P1_CFG_PINS = 6
) (
  input wire logic clk_sys,
  input wire logic [P1_CFG_PINS:0] pin_out,
  input wire logic [P1_CFG_PINS:0] pin_oe,
  input wire logic [P1_CFG_PINS:0] pin_pull_up,
  input wire logic [P1_CFG_PINS:0] pin_pull_down,
  input wire logic [P1_W:0] ext_lvl,
  input wire logic [P1_W:0] ext_en,
  output logic p0_pin7_in,
  output logic [P1_W-1:0] p1_pin_in
);
  logic [P1_W:0] lvl, oe, od, pu, pd;
  logic tog = 1'b0;
  assign oe = (P1_W+1)'(pin_oe);
  assign od = (P1_W+1)'(pin_out);
  assign pu = (P1_W+1)'(pin_pull_up);
  assign pd = (P1_W+1)'(pin_pull_down);
  always @(posedge clk_sys) tog <= ~tog;
  always_comb begin
    for (int i = 0; i <= P1_W; i++) begin
      if (oe[i]) lvl[i] = od[i];
      else if (ext_en[i]) lvl[i] = ext_lvl[i];
      else if (pu[i] || pd[i]) lvl[i] = pu[i];
      else lvl[i] = tog ^ i[0];
    end
  end
  assign p0_pin7_in = lvl[0];
  assign p1_pin_in = lvl[P1_W:1];
endmodule : pad_model

// >>> tb/test_gpio_port_mode_data.sv
// Purpose: self-checking bench for gpio_port_mode_data
// Assumes: byte address is four times the low 12 bits of an offset
// Notes: pad 0 is port 0 pin 7, pads 1..8 port 1 pins 0..7
`timescale 1ns/1ps
module test_gpio_port_mode_data
  import gpio_port_pkg::*;
;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, p0_pin7_latch = 0;
  logic awready, wready, bvalid, arready, rvalid, p0_pin7_in;
  logic [1:0] bresp, rresp, r;
  logic [3:0] wstrb = 4'hf;
  logic [31:0] wdata = '0, rdata, d;
  logic [7:0] p1_pin_in, p1_latch;
  logic [6:0] pin_out, pin_oe, pin_pu, pin_pd;
  logic [NFUNC-1:0] periph_out = '0, periph_in;
  logic [8:0] ext_lvl = '0, ext_en = '1;
  logic [2:0] e;
  logic [ADDR_W-1:0] op_a[3];
  int err_total = 0, n_tests = 0, latch_m = 0, v, m;
  int cfg_m[7] = '{512, 512, 512, 512, 512, 256, 256};
  int pe[4] = '{0, 2, 1, 4};
  int outc[$] = '{2, 4, 6, 7, 8, 12, 14, 16, 17, 20, 22, 23, 24, 25};
  int inc[$] = '{1, 3, 5, 11, 13, 19, 21};
  gpio_port_mode_data dut_u (.clk_sys, .resetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .p0_pin7_in, .p0_pin7_latch, .p1_pin_in, .pin_out, .pin_oe, .pin_pull_up(pin_pu),
    .pin_pull_down(pin_pd), .p1_latch, .periph_out, .periph_in);
  pad_model pad_u (.clk_sys, .pin_out, .pin_oe, .pin_pull_up(pin_pu), .pin_pull_down(pin_pd),
    .ext_lvl, .ext_en, .p0_pin7_in, .p1_pin_in);
  // ********************************
  // clock, bus tasks, checks
  // ********************************
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  function automatic logic [ADDR_W-1:0] ba(input logic [31:0] o);
    return {o[11:0], 2'b00};
  endfunction : ba
  function automatic logic [ADDR_W-1:0] cfa(input int i);
    return ba(i ? PORT1_PIN0_CONFIG_OFS + 2 * i - 2 : PORT0_PIN7_CONFIG_OFS);
  endfunction : cfa
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic st;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : st
  task automatic wr(input logic [ADDR_W-1:0] a, input int x);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    r = bresp;
    bready <= 0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask : rd
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    end_sim();
  end
  initial begin
    void'($urandom(39617));
    op_a = '{ba(PORT1_LEVEL_WORD_OFS), ba(PORT1_BIT_RAISE_OFS), ba(PORT1_BIT_LOWER_OFS)};
    repeat (20) @(posedge clk_sys);
    resetn <= 1;
    periph_out <= NFUNC'($urandom);
    @(posedge clk_sys);
    #1;
    chk(pin_pd, 7'h1f);
    chk(pin_pu, 7'h60);
    for (int i = 0; i < 7; i++) begin
      rd(cfa(i));
      chk(d, cfg_m[i]);
      v = $urandom;
      wstrb <= 4'($urandom);
      wr(cfa(i), v);
      chk(r, RESP_OKAY);
      m = (wstrb[0] ? 'h1f : 0) | (wstrb[1] ? 'h300 : 0);
      wstrb <= 4'hf;
      rd(cfa(i));
      chk(d, (v & m | cfg_m[i] & ~m) & 'h31f);
      wr(cfa(i), 16'h0200);
    end
    ext_en <= 9'h1fd;
    for (int p = 0; p < 4; p++) begin
      wr(cfa(1), p << 8);
      st();
      chk({pin_oe[1], pin_pu[1], pin_pd[1]}, pe[p]);
      rd(op_a[0]);
      if (p > 0) chk(d[0], p == 1);
    end
    ext_en <= '1;
    wr(cfa(0), 16'h010f);
    st();
    chk({pin_oe[0], pin_pu[0], pin_pd[0]}, 0);
    wr(cfa(0), 16'h0012);
    st();
    chk({pin_oe[0], pin_out[0]}, {1'b1, periph_out[18]});
    wr(cfa(0), 16'h0300);
    p0_pin7_latch <= 1;
    st();
    chk({pin_oe[0], pin_out[0]}, 2'h3);
    wr(cfa(0), 16'h0200);
    for (int c = 1; c < 26; c++) begin
      wr(cfa(2), 'h200 | c);
      ext_lvl[2] <= 1'($urandom);
      st();
      e = c inside {outc} ? 3'h4 : c inside {9, 10} ? {~periph_out[c], 2'h1}
        : c inside {15, 18} ? 0 : 1;
      chk({pin_oe[2], pin_pu[2], pin_pd[2]}, e);
      if (c inside {outc}) chk(pin_out[2], periph_out[c]);
      if (c inside {inc}) chk(periph_in[c], ext_lvl[2]);
    end
    wr(cfa(2), 16'h0200);
    wr(cfa(0), 16'h0205);
    wr(cfa(3), 16'h0205);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      ext_lvl[3:0] <= k ? 4'h8 : 4'h1;
      st();
      chk(periph_in[5], !k);
    end
    wr(cfa(0), 16'h0200);
    wr(cfa(1), 16'h0205);
    ext_lvl[3:0] <= 4'h2;
    st();
    chk(periph_in[5], 1);
    for (int i = 1; i < 7; i++) wr(cfa(i), 16'h0300);
    ext_lvl <= 9'h100;
    for (int k = 0; k < 9; k++) begin
      v = $urandom;
      wr(op_a[k % 3], v);
      latch_m = k % 3 == 0 ? v & 'hff : k % 3 == 1 ? latch_m | v & 'hff : latch_m & ~v & 'hff;
      st();
      chk(p1_latch, latch_m);
      rd(op_a[k % 3]);
      chk(r, RESP_OKAY);
      chk(d, k % 3 ? 0 : 'h80 | latch_m & 'h3f);
    end
    wr(14'h3f0, 'hff);
    chk(r, RESP_SLVERR);
    rd(14'h3f0);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    chk(p1_latch, latch_m);
    end_sim();
  end
endmodule : test_gpio_port_mode_data
